/* design/csf_status_top.sv */
// Status word flag logic with an AXI4-Lite register slave.
// Function
// - Half carry changes only on byte operations.
// - Half carry from bit-3 carry or borrow.
// - Overflow on signed add or subtract overflow.
// - Overflow when product exceeds one byte.
// - Overflow on divide by zero.
`timescale 1ns/100ps
module csf_status_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // Write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // Write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // Read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // Read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Status word and active bank base
    output logic [7:0]       program_status_word,
    output logic [4:0]       bank_base_addr
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic             awready;
        logic             wready;
        logic             aw_held;
        logic [7:0]       aw_addr;
        logic             w_held;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        logic [1:0]       bresp;
        logic             bvalid;
        logic             arready;
        logic [31:0]      rdata;
        logic [1:0]       rresp;
        logic             rvalid;
        logic [7:0]       status;
        csf_pkg::csf_op_e op;
        logic             wide;
        logic [7:0]       opa;
        logic [7:0]       opb;
        logic [7:0]       result;
        logic [4:0]       bank_base;
    } csf_state_s;

    csf_state_s         state_reg;
    csf_state_s         state_next;
    csf_pkg::csf_req_s  req;
    csf_pkg::csf_flag_s flags;
    logic               go;
    logic               wr_fire;
    logic [31:0]        wmask;
    logic [31:0]        status_wr;

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction : strb_mask

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction : merge

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a == csf_pkg::STATUS_OFFSET) || (a == csf_pkg::CTRL_OFFSET) ||
                     (a == csf_pkg::OPA_OFFSET) || (a == csf_pkg::OPB_OFFSET) ||
                     (a == csf_pkg::RESULT_OFFSET) || (a == csf_pkg::BANKADR_OFFSET);
    endfunction : known_addr

    // ==========================================================
    // Flag evaluation
    // ==========================================================
    always_comb begin
        req.op       = state_reg.op;
        req.wide     = state_reg.wide;
        req.a        = state_reg.opa;
        req.b        = state_reg.opb;
        req.carry_in = state_reg.status[csf_pkg::CARRY_BIT];
    end

    csf_flag_calc u_calc (
        .req   (req),
        .flags (flags)
    );

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        state_next = state_reg;
        wmask      = strb_mask(state_reg.w_strb);
        status_wr  = merge({24'h0, state_reg.status}, state_reg.w_data, wmask);
        wr_fire    = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
        go         = 1'b0;

        // Address and data are captured independently, in either order.
        if (s_axi_awvalid && state_reg.awready) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
            state_next.awready = 1'b0;
        end
        if (s_axi_wvalid && state_reg.wready) begin
            state_next.w_held = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
            state_next.wready = 1'b0;
        end

        if (wr_fire) begin
            state_next.aw_held = 1'b0;
            state_next.w_held  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = known_addr(state_reg.aw_addr) ? csf_pkg::AXI_OKAY
                                                               : csf_pkg::AXI_SLVERR;
            case (state_reg.aw_addr)
                csf_pkg::STATUS_OFFSET: begin
                    state_next.status = status_wr[7:0];
                end
                csf_pkg::CTRL_OFFSET: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.op   = csf_pkg::csf_op_e'(
                                          state_reg.w_data[csf_pkg::CTRL_OP_LSB +: 3]);
                        state_next.wide = state_reg.w_data[csf_pkg::CTRL_WIDE_BIT];
                    end
                    go = state_reg.w_strb[1] && state_reg.w_data[csf_pkg::CTRL_GO_BIT];
                end
                csf_pkg::OPA_OFFSET: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.opa = state_reg.w_data[7:0];
                    end
                end
                csf_pkg::OPB_OFFSET: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.opb = state_reg.w_data[7:0];
                    end
                end
                default: begin
                    state_next.bresp = state_next.bresp;
                end
            endcase
        end

        // The go strobe uses the operation already held, so program the
        // operation in one write and start it in a later one.
        if (go && state_reg.op != csf_pkg::OP_NONE) begin
            state_next.result = flags.result;
            if (flags.upd_half) begin
                state_next.status[csf_pkg::HALF_BIT] = flags.half;
            end
            if (flags.upd_ovf) begin
                state_next.status[csf_pkg::OVF_BIT] = flags.ovf;
            end
        end

        // Bank n starts at internal address 8n.
        state_next.bank_base = {state_next.status[csf_pkg::BANK_HI_BIT:csf_pkg::BANK_LO_BIT],
                                3'h0};

        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid  = 1'b0;
            state_next.awready = 1'b1;
            state_next.wready  = 1'b1;
        end

        if (s_axi_arvalid && state_reg.arready) begin
            state_next.arready = 1'b0;
            state_next.rvalid  = 1'b1;
            state_next.rresp   = known_addr(s_axi_araddr) ? csf_pkg::AXI_OKAY
                                                          : csf_pkg::AXI_SLVERR;
            case (s_axi_araddr)
                csf_pkg::STATUS_OFFSET:  state_next.rdata = {24'h0, state_reg.status};
                csf_pkg::CTRL_OFFSET:    state_next.rdata = {27'h0, state_reg.wide,
                                                             1'b0, state_reg.op};
                csf_pkg::OPA_OFFSET:     state_next.rdata = {24'h0, state_reg.opa};
                csf_pkg::OPB_OFFSET:     state_next.rdata = {24'h0, state_reg.opb};
                csf_pkg::RESULT_OFFSET:  state_next.rdata = {24'h0, state_reg.result};
                csf_pkg::BANKADR_OFFSET: state_next.rdata = {27'h0, state_reg.bank_base};
                default:                 state_next.rdata = 32'h0;
            endcase
        end
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid  = 1'b0;
            state_next.arready = 1'b1;
        end
    end

    // ==========================================================
    // Registers
    // ==========================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg         <= '0;
            state_reg.awready <= 1'b1;
            state_reg.wready  <= 1'b1;
            state_reg.arready <= 1'b1;
            state_reg.status  <= csf_pkg::STATUS_RESET;
            state_reg.op      <= csf_pkg::OP_NONE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign s_axi_awready       = state_reg.awready;
    assign s_axi_wready        = state_reg.wready;
    assign s_axi_bresp         = state_reg.bresp;
    assign s_axi_bvalid        = state_reg.bvalid;
    assign s_axi_arready       = state_reg.arready;
    assign s_axi_rdata         = state_reg.rdata;
    assign s_axi_rresp         = state_reg.rresp;
    assign s_axi_rvalid        = state_reg.rvalid;
    assign program_status_word = state_reg.status;
    assign bank_base_addr      = state_reg.bank_base;

endmodule : csf_status_top

/* design/csf_pkg.sv */
// Package with register layout, operation codes and carriers for the status flag block.
package csf_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [7:0] STATUS_OFFSET  = 8'h00;
    localparam logic [7:0] CTRL_OFFSET    = 8'h04;
    localparam logic [7:0] OPA_OFFSET     = 8'h08;
    localparam logic [7:0] OPB_OFFSET     = 8'h0c;
    localparam logic [7:0] RESULT_OFFSET  = 8'h10;
    localparam logic [7:0] BANKADR_OFFSET = 8'h14;
    localparam logic [7:0] STATUS_RESET   = 8'h00;
    localparam int         CARRY_BIT      = 7;
    localparam int         HALF_BIT       = 6;
    localparam int         USER_A_BIT     = 5;
    localparam int         BANK_HI_BIT    = 4;
    localparam int         BANK_LO_BIT    = 3;
    localparam int         OVF_BIT        = 2;
    localparam int         USER_B_BIT     = 1;
    localparam int         PAR_BIT        = 0;
    localparam int         CTRL_OP_LSB    = 0;
    localparam int         CTRL_WIDE_BIT  = 4;
    localparam int         CTRL_GO_BIT    = 8;
    localparam logic [1:0] AXI_OKAY       = 2'h0;
    localparam logic [1:0] AXI_SLVERR     = 2'h2;

    // ==========================================================
    // Operations
    // ==========================================================
    typedef enum logic [2:0] {
        OP_ADD,
        OP_ADDC,
        OP_SUB,
        OP_SUBB,
        OP_MUL,
        OP_DIV,
        OP_NONE
    } csf_op_e;

    typedef struct packed {
        csf_op_e    op;
        logic       wide;
        logic [7:0] a;
        logic [7:0] b;
        logic       carry_in;
    } csf_req_s;

    typedef struct packed {
        logic       upd_half;
        logic       half;
        logic       upd_ovf;
        logic       ovf;
        logic [7:0] result;
    } csf_flag_s;

endpackage : csf_pkg

/* design/csf_flag_calc.sv */
// Combinational flag evaluation for one arithmetic operation.
`timescale 1ns/100ps
module csf_flag_calc (
    // Operation
    input  wire csf_pkg::csf_req_s  req,
    // Flag outcome
    output csf_pkg::csf_flag_s      flags
);
    logic [4:0]  low_nib;
    logic [8:0]  full;
    logic [15:0] prod;
    logic        cin;

    always_comb begin
        flags   = '0;
        cin     = (req.op == csf_pkg::OP_ADDC || req.op == csf_pkg::OP_SUBB) ? req.carry_in
                                                                             : 1'b0;
        low_nib = '0;
        full    = '0;
        prod    = req.a * req.b;
        case (req.op)
            csf_pkg::OP_ADD, csf_pkg::OP_ADDC: begin
                low_nib        = {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]} + {4'h0, cin};
                full           = {1'b0, req.a} + {1'b0, req.b} + {8'h00, cin};
                flags.result   = full[7:0];
                flags.upd_half = !req.wide;
                flags.half     = low_nib[4];
                flags.upd_ovf  = 1'b1;
                flags.ovf      = (req.a[7] == req.b[7]) && (full[7] != req.a[7]);
            end
            csf_pkg::OP_SUB, csf_pkg::OP_SUBB: begin
                low_nib        = {1'b0, req.a[3:0]} - {1'b0, req.b[3:0]} - {4'h0, cin};
                full           = {1'b0, req.a} - {1'b0, req.b} - {8'h00, cin};
                flags.result   = full[7:0];
                flags.upd_half = !req.wide;
                flags.half     = low_nib[4];
                flags.upd_ovf  = 1'b1;
                flags.ovf      = (req.a[7] != req.b[7]) && (full[7] != req.a[7]);
            end
            csf_pkg::OP_MUL: begin
                flags.result  = prod[7:0];
                flags.upd_ovf = 1'b1;
                flags.ovf     = |prod[15:8];
            end
            csf_pkg::OP_DIV: begin
                flags.result  = (req.b == 8'h00) ? 8'h00 : req.a / req.b;
                flags.upd_ovf = 1'b1;
                flags.ovf     = (req.b == 8'h00);
            end
            default: begin
                flags = '0;
            end
        endcase
    end

endmodule : csf_flag_calc

/* testbench/csf_status_sva.sv */
// Checker for the status flag block: bus handshakes, flag timing and bank mapping.
`timescale 1ns/100ps
module csf_status_sva (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Status outputs
    input wire logic [7:0]  program_status_word,
    input wire logic [4:0]  bank_base_addr
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // Assertions
    // ==========================================================
    bank_map_a: assert property (bank_base_addr == {program_status_word[4:3], 3'h0})
        else $error("bank base does not follow the bank field");
    // Flags may only move at the edge where a write completes.
    flag_edge_a: assert property ($changed(program_status_word[6]) ||
        $changed(program_status_word[2]) |-> $rose(s_axi_bvalid))
        else $error("flag changed outside a write completion");
    wr_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
endmodule : csf_status_sva

bind csf_status_top csf_status_sva u_sva (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .program_status_word(program_status_word), .bank_base_addr(bank_base_addr));

/* testbench/cpu_status_flag_logic_tb_top.sv */
// Self-checking bench for the status flag block driven over its register bus.
`timescale 1ns/100ps
module cpu_status_flag_logic_tb_top;
    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic [7:0]  awaddr  = 8'h00;
    logic [7:0]  araddr  = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, d;
    logic [7:0]  status_word;
    logic [3:0]  wstrb   = 4'hf;
    logic [4:0]  bank;
    int          bad_count       = 0;
    int          samples_checked = 0;

    csf_status_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .program_status_word(status_word), .bank_base_addr(bank));

    always #10 aclk = ~aclk;

    // ==========================================================
    // Reporting
    // ==========================================================
    task test_done;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task hang;
        bad_count++;
        $display("mismatch at %0t: no answer from the bus", $time);
        test_done();
    endtask : hang

    // ==========================================================
    // Bus master
    // ==========================================================
    // Ready is raised only after the answer shows, so the slave must hold it a cycle.
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
        int n;
        awaddr  <= ad;
        wdata   <= dt;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
            if (bvalid) bready <= 1'b1;
        end
        if (n == 40) hang();
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dt, input logic [1:0] er);
        int n;
        araddr  <= ad;
        arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            if (rvalid) rready <= 1'b1;
        end
        if (n == 40) hang();
        rready <= 1'b0;
        dt = rdata;
        chk({30'h0, rresp}, {30'h0, er});
    endtask : axi_rd

    // ==========================================================
    // Scenarios
    // ==========================================================
    // Loads carry, half carry and a set overflow, runs one operation, checks overflow and, except after multiply or divide, half carry.
    task automatic run_op(input csf_pkg::csf_op_e op, input logic wd, ci, ai,
                          input logic [7:0] a, b);
        logic [7:0]  e;
        logic [7:0]  m;
        logic [7:0]  r;
        logic [8:0]  s;
        logic [15:0] p;
        logic [31:0] rd;
        logic        c;
        e = {ci, ai, 3'h0, 1'b1, 2'h0};
        axi_wr(csf_pkg::STATUS_OFFSET, {24'h0, e}, csf_pkg::AXI_OKAY);
        axi_wr(csf_pkg::OPA_OFFSET, {24'h0, a}, csf_pkg::AXI_OKAY);
        axi_wr(csf_pkg::OPB_OFFSET, {24'h0, b}, csf_pkg::AXI_OKAY);
        axi_wr(csf_pkg::CTRL_OFFSET, {27'h0, wd, 1'b0, op}, csf_pkg::AXI_OKAY);
        axi_wr(csf_pkg::CTRL_OFFSET, {23'h0, 1'b1, 3'h0, wd, 1'b0, op}, csf_pkg::AXI_OKAY);
        c = ci && (op == csf_pkg::OP_ADDC || op == csf_pkg::OP_SUBB);
        p = a * b;
        r = 8'h00;
        case (op)
            csf_pkg::OP_ADD, csf_pkg::OP_ADDC: begin
                s = a + b + c;
                r = s[7:0];
                e[6] = wd ? e[6] : (({1'b0, a[3:0]} + b[3:0] + c) > 5'h0f);
                e[2] = (a[7] == b[7]) && (s[7] != a[7]);
            end
            csf_pkg::OP_SUB, csf_pkg::OP_SUBB: begin
                s = a - b - c;
                r = s[7:0];
                e[6] = wd ? e[6] : ({1'b0, a[3:0]} < (b[3:0] + c));
                e[2] = (a[7] != b[7]) && (s[7] != a[7]);
            end
            csf_pkg::OP_MUL: begin
                r    = p[7:0];
                e[2] = |p[15:8];
            end
            default: begin
                r    = (b == 8'h00) ? 8'h00 : a / b;
                e[2] = (b == 8'h00);
            end
        endcase
        // Half carry after multiply or divide is left open, so it is masked out.
        m = (op == csf_pkg::OP_MUL || op == csf_pkg::OP_DIV) ? 8'hbf : 8'hff;
        e = e & m;
        axi_rd(csf_pkg::STATUS_OFFSET, rd, csf_pkg::AXI_OKAY);
        chk(rd & {24'h0, m}, {24'h0, e});
        chk({24'h0, status_word & m}, {24'h0, e});
        axi_rd(csf_pkg::RESULT_OFFSET, rd, csf_pkg::AXI_OKAY);
        chk(rd, {24'h0, r});
    endtask : run_op

    task automatic bank_walk;
        for (int i = 0; i < 4; i++) begin
            axi_wr(csf_pkg::STATUS_OFFSET, i << 3, csf_pkg::AXI_OKAY);
            axi_rd(csf_pkg::BANKADR_OFFSET, d, csf_pkg::AXI_OKAY);
            chk(d, i * 8);
            chk({27'h0, bank}, i * 8);
        end
    endtask : bank_walk

    // With byte lane 0 disabled the status word must keep the last bank field.
    task automatic strobe_mask;
        wstrb <= 4'he;
        axi_wr(csf_pkg::STATUS_OFFSET, 32'h0000_00ff, csf_pkg::AXI_OKAY);
        wstrb <= 4'hf;
        chk({24'h0, status_word}, 32'h0000_0018);
    endtask : strobe_mask

    task automatic unmapped;
        axi_wr(8'h18, 32'hffff_ffff, csf_pkg::AXI_SLVERR);
        chk({24'h0, status_word}, 32'h0000_0018);
        axi_rd(8'h18, d, csf_pkg::AXI_SLVERR);
        chk(d, 32'h0);
    endtask : unmapped

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(csf_pkg::STATUS_OFFSET, d, csf_pkg::AXI_OKAY);
        chk(d, 32'h0);
        bank_walk();
        strobe_mask();
        unmapped();
        run_op(csf_pkg::OP_ADD, 1'b0, 1'b0, 1'b0, 8'h0f, 8'h01);
        run_op(csf_pkg::OP_ADD, 1'b0, 1'b0, 1'b1, 8'h70, 8'h10);
        run_op(csf_pkg::OP_ADDC, 1'b0, 1'b1, 1'b0, 8'h0e, 8'h01);
        run_op(csf_pkg::OP_SUB, 1'b0, 1'b0, 1'b0, 8'h10, 8'h01);
        run_op(csf_pkg::OP_SUB, 1'b0, 1'b0, 1'b0, 8'h80, 8'h01);
        run_op(csf_pkg::OP_SUBB, 1'b0, 1'b1, 1'b1, 8'h05, 8'h04);
        run_op(csf_pkg::OP_MUL, 1'b0, 1'b0, 1'b0, 8'h10, 8'h10);
        run_op(csf_pkg::OP_MUL, 1'b0, 1'b0, 1'b0, 8'h0f, 8'h11);
        run_op(csf_pkg::OP_DIV, 1'b0, 1'b0, 1'b0, 8'h05, 8'h00);
        run_op(csf_pkg::OP_DIV, 1'b0, 1'b0, 1'b0, 8'h05, 8'h01);
        run_op(csf_pkg::OP_ADD, 1'b1, 1'b0, 1'b0, 8'h0f, 8'h01);
        test_done();
    end
endmodule : cpu_status_flag_logic_tb_top
